// >>> rtl/tws_map.vh
// Register offsets, field positions, reset values, status codes and interrupt bits for the two-wire slave transmitter
`ifndef TWS_MAP_VH
`define TWS_MAP_VH
// APB byte offsets
`define TWS_OFF_CTRL 12'h000
`define TWS_OFF_STAT 12'h004
`define TWS_OFF_DATA 12'h008
`define TWS_OFF_ADDR 12'h00c
`define TWS_OFF_IRQ_STAT 12'h010
`define TWS_OFF_IRQ_MASK 12'h014
`define TWS_OFF_SLEEP 12'h018
// Control fields
`define TWS_CTRL_FLAG 7
`define TWS_CTRL_ACK 6
`define TWS_CTRL_STA 5
`define TWS_CTRL_STO 4
`define TWS_CTRL_WCOL 3
`define TWS_CTRL_EN 2
`define TWS_CTRL_IE 0
`define TWS_CTRL_RESET 8'h00
`define TWS_ADDR_RESET 8'h00
`define TWS_DATA_RESET 8'hff
// Status codes, prescaler bits zero
`define TWS_ST_SLA_R 8'ha8
`define TWS_ST_ARB_SLA_R 8'hb0
`define TWS_ST_DATA_ACK 8'hb8
`define TWS_ST_DATA_NACK 8'hc0
`define TWS_ST_LAST_ACK 8'hc8
`define TWS_ST_NONE 8'hf8
// Interrupt status bits
`define TWS_IRQ_DONE 0
`define TWS_IRQ_WAKE 1
`define TWS_IRQ_START 2
`define TWS_IRQ_W 3
`endif

// >>> rtl/tws_sync.v
// Two-flop synchroniser for the bus pins
`timescale 1ns/100ps
`default_nettype none
module tws_sync (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Asynchronous level in, synchronised level out
   input wire async_in,
   output reg sync_out
);
   reg meta;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/tws_cond.v
// Start, stop and clock-edge detection on synchronised bus lines
`timescale 1ns/100ps
`default_nettype none
module tws_cond (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Synchronised bus levels
   input wire scl_s,
   input wire sda_s,
   // Detected events, one-cycle pulses
   output wire scl_rise,
   output wire scl_fall,
   output wire start_det,
   output wire stop_det,
   // Bus busy between start and stop
   output reg bus_busy
);
   reg scl_d;
   reg sda_d;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         bus_busy <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         if (start_det)
            bus_busy <= 1'b1;
         else if (stop_det)
            bus_busy <= 1'b0;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   // Data may only change with clock low; a change with clock high is a condition
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
endmodule
`default_nettype wire

// >>> rtl/tws_slave_tx.v
// Two-wire slave transmitter with APB registers and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "tws_map.vh"
module tws_slave_tx (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Bus clock line, open drain
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   // Bus data line, open drain
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // Master side hooks
   input wire arb_lost,
   output reg start_pending,
   // Interrupt and wake-up
   output reg irq,
   output reg wake
);
   localparam S_IDLE = 3'd0;
   localparam S_ADDR = 3'd1;
   localparam S_AACK = 3'd2;
   localparam S_SEND = 3'd3;
   localparam S_MACK = 3'd4;
   localparam S_HOLD = 3'd5;
   localparam S_DRAIN = 3'd6;

   wire scl_s;
   wire sda_s;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire bus_busy;

   reg [7:0] ctrl;
   reg [7:0] own_addr;
   reg [7:0] data;
   reg [7:0] status;
   reg [3:0] irq_stat;
   reg [3:0] irq_mask;
   reg sleep_deep;
   reg [2:0] state;
   reg [7:0] shift;
   reg [3:0] bit_cnt;
   reg last_byte;
   reg woke;
   reg [7:0] next_status;
   reg [3:0] ev;

   wire flag = ctrl[`TWS_CTRL_FLAG];
   wire ack_en = ctrl[`TWS_CTRL_ACK];
   wire enable = ctrl[`TWS_CTRL_EN];
   // Write lands on the access edge, where pready is sampled high
   wire wr_en = psel & penable & pwrite & pready;
   wire rd_en = psel & ~penable & ~pwrite;
   wire flag_clr = wr_en && paddr == `TWS_OFF_CTRL && pwdata[`TWS_CTRL_FLAG];

   tws_sync u_sync_scl (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(scl_in),
      .sync_out(scl_s)
   );

   tws_sync u_sync_sda (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(sda_in),
      .sync_out(sda_s)
   );

   tws_cond u_cond (
      .pclk(pclk),
      .presetn(presetn),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det),
      .bus_busy(bus_busy)
   );

   // Address match; decoding shared by wake and normal paths
   function addr_match;
      input [7:0] rx;
      input [7:0] oa;
      input ack;
      begin
         addr_match = ack && ((rx[7:1] == oa[7:1]) || (rx[7:1] == 7'h00 && oa[0]));
      end
   endfunction

   // Bus protocol engine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         shift <= 8'h00;
         bit_cnt <= 4'd0;
         last_byte <= 1'b0;
         woke <= 1'b0;
         next_status <= `TWS_ST_NONE;
         ev <= 4'h0;
         sda_out <= 1'b1;
         sda_oe <= 1'b0;
      end else begin
         ev <= 4'h0;
         if (!enable || stop_det) begin
            state <= S_IDLE;
            sda_oe <= 1'b0;
         end else if (start_det) begin
            state <= S_ADDR;
            bit_cnt <= 4'd0;
            sda_oe <= 1'b0;
            ev[`TWS_IRQ_START] <= 1'b1;
         end else begin
            case (state)
               S_ADDR: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'd1;
                  end else if (scl_fall && bit_cnt == 4'd8) begin
                     if (addr_match(shift, own_addr, ack_en) && shift[0]) begin
                        sda_out <= 1'b0;
                        sda_oe <= 1'b1;
                        state <= S_AACK;
                        woke <= sleep_deep;
                        next_status <= arb_lost ? `TWS_ST_ARB_SLA_R : `TWS_ST_SLA_R;
                     end else begin
                        // Write direction belongs to the receiver block
                        state <= S_IDLE;
                     end
                  end
               end
               S_AACK, S_MACK: begin
                  if (scl_fall && !flag_clr && !flag) begin
                     // status posted at end of ack bit
                     sda_oe <= 1'b0;
                     state <= S_HOLD;
                     ev[`TWS_IRQ_DONE] <= 1'b1;
                     ev[`TWS_IRQ_WAKE] <= woke;
                  end else if (scl_rise && state == S_MACK) begin
                     if (sda_s) begin
                        next_status <= `TWS_ST_DATA_NACK;
                     end else if (last_byte) begin
                        next_status <= `TWS_ST_LAST_ACK;
                     end else begin
                        next_status <= `TWS_ST_DATA_ACK;
                     end
                  end
               end
               S_HOLD: begin
                  if (flag_clr) begin
                     woke <= 1'b0;
                     if (status == `TWS_ST_DATA_NACK || status == `TWS_ST_LAST_ACK) begin
                        state <= S_IDLE;
                     end else begin
                        shift <= data;
                        // cleared acknowledge marks the last byte
                        last_byte <= ~pwdata[`TWS_CTRL_ACK];
                        bit_cnt <= 4'd0;
                        sda_out <= data[7];
                        sda_oe <= ~data[7];
                        state <= S_SEND;
                     end
                  end
               end
               S_SEND: begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'd7) begin
                        sda_oe <= 1'b0;
                        state <= S_MACK;
                     end else begin
                        sda_out <= shift[6];
                        sda_oe <= ~shift[6];
                        shift <= {shift[6:0], 1'b1};
                     end
                     bit_cnt <= bit_cnt + 4'd1;
                  end
               end
               S_DRAIN: state <= S_IDLE;
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // Registers, completion flag and status
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `TWS_CTRL_RESET;
         own_addr <= `TWS_ADDR_RESET;
         data <= `TWS_DATA_RESET;
         status <= `TWS_ST_NONE;
         irq_stat <= 4'h0;
         irq_mask <= 4'h0;
         sleep_deep <= 1'b0;
         start_pending <= 1'b0;
      end else begin
         if (wr_en) begin
            case (paddr)
               `TWS_OFF_CTRL: begin
                  ctrl[6:4] <= pwdata[6:4];
                  ctrl[`TWS_CTRL_EN] <= pwdata[`TWS_CTRL_EN];
                  ctrl[`TWS_CTRL_IE] <= pwdata[`TWS_CTRL_IE];
                  if (pwdata[`TWS_CTRL_FLAG])
                     ctrl[`TWS_CTRL_FLAG] <= 1'b0;
                  if (pwdata[`TWS_CTRL_FLAG] && pwdata[`TWS_CTRL_STA] && state == S_HOLD &&
                      (status == `TWS_ST_DATA_NACK || status == `TWS_ST_LAST_ACK))
                     start_pending <= 1'b1;
               end
               `TWS_OFF_DATA: begin
                  // Data may only change while the flag is set
                  if (flag)
                     data <= pwdata[7:0];
                  else
                     ctrl[`TWS_CTRL_WCOL] <= 1'b1;
               end
               `TWS_OFF_ADDR: own_addr <= pwdata[7:0];
               `TWS_OFF_IRQ_STAT: irq_stat <= irq_stat & ~pwdata[3:0];
               `TWS_OFF_IRQ_MASK: irq_mask <= pwdata[3:0];
               `TWS_OFF_SLEEP: sleep_deep <= pwdata[0];
               default: ;
            endcase
         end
         if (flag && wr_en && paddr == `TWS_OFF_DATA)
            ctrl[`TWS_CTRL_WCOL] <= 1'b0;
         if (start_pending && !bus_busy)
            start_pending <= 1'b0;
         // Hardware set wins over software clear
         irq_stat <= (wr_en && paddr == `TWS_OFF_IRQ_STAT ? irq_stat & ~pwdata[3:0] : irq_stat) | ev;
         if (ev[`TWS_IRQ_DONE]) begin
            ctrl[`TWS_CTRL_FLAG] <= 1'b1;
            status <= next_status;
            if (ev[`TWS_IRQ_WAKE])
               sleep_deep <= 1'b0;
         end else if (!flag || flag_clr) begin
            status <= `TWS_ST_NONE;
         end
      end
   end

   // APB read path, outputs and line hold
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         scl_out <= 1'b1;
         scl_oe <= 1'b0;
         irq <= 1'b0;
         wake <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable && paddr > `TWS_OFF_SLEEP;
         if (rd_en) begin
            case (paddr)
               `TWS_OFF_CTRL: prdata <= {24'h000000, ctrl};
               `TWS_OFF_STAT: prdata <= {24'h000000, status[7:3], 3'b000};
               `TWS_OFF_DATA: prdata <= {24'h000000, data};
               `TWS_OFF_ADDR: prdata <= {24'h000000, own_addr};
               `TWS_OFF_IRQ_STAT: prdata <= {28'h0000000, irq_stat};
               `TWS_OFF_IRQ_MASK: prdata <= {28'h0000000, irq_mask};
               `TWS_OFF_SLEEP: prdata <= {31'h00000000, sleep_deep};
               default: prdata <= 32'h00000000;
            endcase
         end
         scl_out <= 1'b0;
         // stretch while flag set in addressed transfer
         scl_oe <= enable && state == S_HOLD && !flag_clr;
         irq <= |(irq_stat & irq_mask);
         wake <= irq_stat[`TWS_IRQ_WAKE];
      end
   end
endmodule
`default_nettype wire

// >>> tb/tws_assertions.sv
// Bound checker watching the two-wire slave transmitter ports
`timescale 1ns/100ps
`default_nettype none
`include "tws_map.vh"
module tws_assertions (
   // APB side
   input wire logic pclk, presetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic pready, pslverr,
   // Bus lines and side outputs
   input wire logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe,
   input wire logic arb_lost, start_pending, irq, wake
);
   logic rd_stat;
   logic clr_wr;
   assign rd_stat = pready && psel && !pwrite && paddr == `TWS_OFF_STAT;
   // Flag clear lands on the access edge; the clock release may lag a cycle
   assign clr_wr = pready && psel && pwrite && paddr == `TWS_OFF_CTRL && pwdata[7];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one: assert property (pready |=> !pready)
      else $error("pready stood longer than one cycle");
   a_ready_phase: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   a_err_span: assert property (pslverr |-> pready && paddr > 12'h018)
      else $error("pslverr on a mapped address");
   a_stat_code: assert property (rd_stat |-> prdata[31:8] == 24'h0 &&
      prdata[7:0] inside {8'ha8, 8'hb0, 8'hb8, 8'hc0, 8'hc8, 8'hf8})
      else $error("status outside the code set");
   a_stat_hold: assert property (rd_stat && prdata[7:0] inside
      {8'ha8, 8'hb0, 8'hb8} |-> scl_oe)
      else $error("clock free while addressed status stands");
   a_hold_flag: assert property (scl_oe && !clr_wr && !$past(clr_wr) |=> scl_oe)
      else $error("clock released without flag clear");
   a_release_clk: assert property (clr_wr && scl_oe |-> ##[1:2] !scl_oe)
      else $error("clock not released after flag clear");
   a_sda_drain: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   a_wake_hold: assert property ($rose(wake) |-> ##[0:60] scl_oe)
      else $error("no clock hold after wake");
   c_last_ack: cover property (rd_stat && prdata[7:0] == `TWS_ST_LAST_ACK);
   c_start: cover property ($rose(start_pending));
   c_wake: cover property ($rose(wake));
endmodule
bind tws_slave_tx tws_assertions u_chk (.*);
`default_nettype wire

// >>> tb/tws_bus_master.sv
// Behavioural bus master that reads bytes from the slave
`timescale 1ns/100ps
`default_nettype none
module tws_bus_master (
   // Wire levels seen on the bus
   input wire logic scl,
   input wire logic sda,
   // Master pulls, high means released
   output logic m_scl,
   output logic m_sda
);
   initial begin
      m_scl = 1'b1;
      m_sda = 1'b1;
   end
   // Waiting on scl high honours any stretch by the slave
   task put(input logic b);
      m_sda = b;
      #40 m_scl = 1'b1;
      wait (scl);
      #80 m_scl = 1'b0;
      #40;
   endtask
   task get(output logic b);
      m_sda = 1'b1;
      #40 m_scl = 1'b1;
      wait (scl);
      #40 b = sda;
      #40 m_scl = 1'b0;
      #40;
   endtask
   task start;
      #80 m_sda = 1'b0;
      #80 m_scl = 1'b0;
      #40;
   endtask
   task stop;
      m_sda = 1'b0;
      #40 m_scl = 1'b1;
      wait (scl);
      #80 m_sda = 1'b1;
      #80;
   endtask
   task addr(input logic [7:0] a, output logic k);
      for (int i = 7; i >= 0; i--) put(a[i]);
      get(k);
   endtask
   // master acks or not acks each byte
   task rd(input logic ack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get(d[i]);
      put(~ack);
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the two-wire slave transmitter
`timescale 1ns/100ps
`default_nettype none
`include "tws_map.vh"
module tb_top;
   typedef struct packed {
      logic [7:0] oa;
      logic [7:0] ctl;
      logic [7:0] bus;
      logic [7:0] fin;
      logic arb;
      logic ack;
      logic mack;
   } tws_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic arb_lost = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rdv;
   logic err;
   logic k;
   logic [7:0] d;
   int n_mismatch = 0;
   int cmp_count = 0;
   tws_row_t rows [6];
   wire [31:0] prdata;
   wire pready, pslverr, scl_out, scl_oe, sda_out, sda_oe;
   wire start_pending, irq, wake, m_scl, m_sda;
   // Open-drain lines: low while any party pulls
   wire scl_in = m_scl & ~(scl_oe & ~scl_out);
   wire sda_in = m_sda & ~(sda_oe & ~sda_out);
   tws_slave_tx dut (.*);
   tws_bus_master m (.scl(scl_in), .sda(sda_in), .m_scl(m_scl), .m_sda(m_sda));
   initial forever #10 pclk = ~pclk;
   // Tests need well under 100 us
   initial begin
      #500000;
      n_mismatch++;
      close_out;
   end
   task close_out;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rst;
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Done only; a start event would wake the waits too early
      apb(1'b1, `TWS_OFF_IRQ_MASK, 32'h1);
   endtask
   task wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 4000) begin
         @(posedge pclk);
         n++;
      end
      chk("irq", irq, 32'h1);
   endtask
   // Clears done, loads a byte, releases the clock, checks the outcome
   task send(input logic [7:0] b, input logic ae, input logic ma, input logic [7:0] st);
      apb(1'b1, `TWS_OFF_IRQ_STAT, 32'h7);
      apb(1'b1, `TWS_OFF_DATA, {24'h0, b});
      apb(1'b1, `TWS_OFF_CTRL, {24'h0, 1'b1, ae, 6'h05});
      m.rd(ma, d);
      chk("byte", d, b);
      wait_irq;
      apb(1'b0, `TWS_OFF_STAT, 32'h0);
      chk("status", rdv, st);
   endtask
   task xfer(input tws_row_t r);
      apb(1'b1, `TWS_OFF_ADDR, r.oa);
      // enable set, acknowledge as the row gives, start and stop clear
      apb(1'b1, `TWS_OFF_CTRL, r.ctl);
      apb(1'b1, `TWS_OFF_IRQ_STAT, 32'h7);
      arb_lost <= r.arb;
      m.start;
      m.addr(r.bus, k);
      chk("addr ack", k, r.ack ? 32'h0 : 32'h1);
      if (r.ack) begin
         wait_irq;
         apb(1'b0, `TWS_OFF_STAT, 32'h0);
         chk("status", rdv, r.arb ? `TWS_ST_ARB_SLA_R : `TWS_ST_SLA_R);
         send(8'h96, 1'b1, 1'b1, `TWS_ST_DATA_ACK);
         send(8'h35, 1'b0, r.mack, r.mack ? `TWS_ST_LAST_ACK : `TWS_ST_DATA_NACK);
         apb(1'b1, `TWS_OFF_CTRL, r.fin);
         // Request lands on the access edge; look once it has settled
         @(posedge pclk);
         chk("start req", start_pending, r.fin[5]);
         apb(1'b0, `TWS_OFF_STAT, 32'h0);
         chk("status", rdv, `TWS_ST_NONE);
         if (r.mack) begin
            m.rd(1'b0, d);
            chk("idle byte", d, 8'hff);
         end
      end
      m.stop;
      arb_lost <= 1'b0;
   endtask
   initial begin
      rows[0] = '{8'h54, 8'h45, 8'h55, 8'hc5, 1'b0, 1'b1, 1'b0};
      rows[1] = '{8'h54, 8'h45, 8'h57, 8'hc5, 1'b0, 1'b0, 1'b0};
      rows[2] = '{8'h55, 8'h45, 8'h01, 8'he5, 1'b0, 1'b1, 1'b1};
      rows[3] = '{8'h54, 8'h45, 8'h01, 8'hc5, 1'b0, 1'b0, 1'b0};
      rows[4] = '{8'h54, 8'h05, 8'h55, 8'hc5, 1'b0, 1'b0, 1'b0};
      rows[5] = '{8'h54, 8'h45, 8'h55, 8'hc5, 1'b1, 1'b1, 1'b0};
      rst;
      foreach (rows[i]) xfer(rows[i]);
      rst;
      apb(1'b0, `TWS_OFF_STAT, 32'h0);
      chk("status", rdv, `TWS_ST_NONE);
      apb(1'b0, `TWS_OFF_ADDR, 32'h0);
      chk("addr reset", rdv, `TWS_ADDR_RESET);
      apb(1'b0, 12'h01c, 32'h0);
      chk("unmapped", err, 32'h1);
      // Data write with the flag clear must be refused
      apb(1'b1, `TWS_OFF_DATA, 32'h11);
      apb(1'b0, `TWS_OFF_CTRL, 32'h0);
      chk("collision", rdv[3], 32'h1);
      apb(1'b1, `TWS_OFF_ADDR, 32'h54);
      apb(1'b1, `TWS_OFF_CTRL, 32'h45);
      apb(1'b1, `TWS_OFF_SLEEP, 32'h1);
      m.start;
      m.addr(8'h55, k);
      chk("wake ack", k, 32'h0);
      wait_irq;
      chk("wake", wake, 32'h1);
      apb(1'b0, `TWS_OFF_SLEEP, 32'h0);
      chk("sleep", rdv, 32'h0);
      apb(1'b1, `TWS_OFF_IRQ_MASK, 32'h0);
      repeat (3) @(posedge pclk);
      chk("masked", irq, 32'h0);
      apb(1'b1, `TWS_OFF_IRQ_MASK, 32'h7);
      apb(1'b1, `TWS_OFF_IRQ_STAT, 32'h7);
      repeat (3) @(posedge pclk);
      chk("cleared", irq, 32'h0);
      chk("held", scl_oe, 32'h1);
      send(8'h5a, 1'b0, 1'b0, `TWS_ST_DATA_NACK);
      apb(1'b1, `TWS_OFF_CTRL, 32'hc5);
      m.stop;
      close_out;
   end
endmodule
`default_nettype wire
